/* hdl/srd_pkg.sv */
package srd_pkg;
   // Register space geometry
   localparam int          ADDR_W   = 20;
   localparam int          DATA_W   = 32;
   localparam int          NPORT    = 8;
   localparam logic [19:0] LT_LO    = 20'h00000;
   localparam logic [19:0] LT_HI    = 20'h000fc;
   localparam logic [19:0] PHY_LO   = 20'h00100;
   localparam logic [19:0] PHY_HI   = 20'h003fc;
   localparam logic [19:0] EM_LO    = 20'h01000;
   localparam logic [19:0] EM_HI    = 20'h013bc;
   localparam logic [19:0] VND_LO   = 20'h10000;
   localparam logic [19:0] VND_HI   = 20'h14ffc;
   localparam logic [19:0] SWF_LO   = 20'h1aa00;
   localparam logic [19:0] TWI_LO   = 20'h1ab00;
   localparam logic [19:0] UTIL_LO  = 20'h1ac00;
   localparam logic [19:0] GRP_SPAN = 20'h00100;
   // Per-port field register: base + port * stride, broadcast at slot 8
   localparam logic [7:0]  FLD_PAGE = 8'h10;
   localparam logic [3:0]  FLD_BC   = 4'h8;
   localparam int          DW_BIT   = 2;
   // Field layout of the per-port register
   localparam logic [31:0] M_RO     = 32'h0000000f;
   localparam logic [31:0] M_BOOT   = 32'h00000008;
   localparam logic [31:0] M_RW     = 32'h000000f0;
   localparam logic [31:0] M_W1C    = 32'h00000f00;
   localparam logic [31:0] M_W0C    = 32'h0000f000;
   localparam logic [31:0] M_W1S    = 32'h000f0000;
   localparam logic [31:0] M_RC     = 32'h00f00000;
   localparam int          LANE4X_BIT = 0;
   // Cycles the strap synchroniser needs before it is trusted
   localparam logic [1:0]  STRAP_WAIT = 2'h3;

   typedef enum logic [2:0] {
      SRD_GRP_NONE, SRD_GRP_LT, SRD_GRP_PHY, SRD_GRP_EM,
      SRD_GRP_VND, SRD_GRP_SWF, SRD_GRP_TWI, SRD_GRP_UTIL
   } srd_grp_e;

   typedef enum logic [1:0] {SRD_WAIT, SRD_BOOT, SRD_RUN} srd_boot_e;
endpackage : srd_pkg

/* hdl/srd_field.sv */
`timescale 1ns/100ps
`default_nettype none
module srd_field #(
   parameter int          W      = 32,
   parameter logic [31:0] RO_M   = 32'h0,
   parameter logic [31:0] BOOT_M = 32'h0,
   parameter logic [31:0] RW_M   = 32'h0,
   parameter logic [31:0] W1C_M  = 32'h0,
   parameter logic [31:0] W0C_M  = 32'h0,
   parameter logic [31:0] W1S_M  = 32'h0,
   parameter logic [31:0] RC_M   = 32'h0
) (
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic         boot_in,
   input  wire logic         wr_in,
   input  wire logic         rd_in,
   input  wire logic [W-1:0] wdata_in,
   input  wire logic [W-1:0] hw_set_in,
   input  wire logic [W-1:0] hw_clr_in,
   output logic      [W-1:0] value_out,
   output logic      [W-1:0] trigger_out
);
   typedef struct packed {
      logic [W-1:0] value;
      logic [W-1:0] trigger;
   } srd_fld_s;

   srd_fld_s st;
   srd_fld_s next_st;
   logic [W-1:0] live_m;

   assign live_m = W'(RO_M & ~BOOT_M);

   // Each access type owns its own bits; sets win over clears landing in the same cycle
   always_comb begin
      next_st.trigger = wr_in ? (wdata_in & W'(W1S_M)) : '0; // RL8
      next_st.value =
         (live_m & hw_set_in)
         | (W'(BOOT_M) & ((wr_in && boot_in) ? wdata_in : st.value))       // RL2
         | (W'(RW_M) & (wr_in ? wdata_in : st.value))                       // RL1
         | (W'(W1C_M) & (wr_in ? (st.value & ~wdata_in) : st.value))        // RL6
         | (W'(W0C_M) & (wr_in ? (st.value & wdata_in) : st.value))         // RL7
         | (W'(W1S_M) & ((st.value & ~hw_clr_in) | (wr_in ? wdata_in : '0))) // RL8
         | (W'(RC_M) & (wr_in ? wdata_in : (rd_in ? '0 : st.value)))        // RL9
         | (W'(W1C_M | W0C_M | RC_M) & hw_set_in);
   end

   // Single state register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign value_out   = st.value;
   assign trigger_out = st.trigger;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   chk_w1c_clear: assert property (wr_in && (hw_set_in & W'(W1C_M)) == '0 |=> // RL6
      (value_out & W'(W1C_M)) == ($past(value_out) & ~$past(wdata_in) & W'(W1C_M)))
      else $error("write-one-clear bits wrong after write");
   chk_rc_clear: assert property (rd_in && !wr_in && (hw_set_in & W'(RC_M)) == '0 |=> // RL9
      (value_out & W'(RC_M)) == '0)
      else $error("clear-on-read bits not cleared");
   chk_ro_hold: assert property (wr_in && !boot_in |=> // RL2
      (value_out & W'(BOOT_M)) == ($past(value_out) & W'(BOOT_M)))
      else $error("read-only bit took a write outside boot");
endmodule : srd_field
`default_nettype wire

/* hdl/srd_decode.sv */
`timescale 1ns/100ps
`default_nettype none
// What the document requires of this block and its users
// RL1 - Read/write registers stay readable and writable during the boot load; the code takes only boot-port writes then, no maintenance requests.
// RL2 - Read-only bits refuse writes during boot unless marked boot-writable.
// RL3 - After reset, boot load of registers from serial EEPROM runs first.
// RL4 - Master avoids reserved addresses; their data and effects are undefined.
// RL5 - Master writes zero into reserved fields.
// RL6 - Write-one-clear: read value, ones clear bits, zeros leave them.
// RL7 - Write-zero-clear: read value, zeros clear bits, ones leave them.
// RL8 - Write-one-set: ones set bits and trigger events, zeros do nothing.
// RL9 - Clear-on-read bits clear after being read; direct writes allowed.
// RL10 - Registers are 32-bit words at word-aligned offsets.
// RL11 - Offset bit 2 picks word 1 of the 64-bit double-word below.
// RL12 - Eight ports; even ports 1x/4x capable, odd ports 1x only.
// RL13 - Broadcast write updates that register in every powered-up port.
// RL14 - Broadcast read returns the port 0 instance.
// RL15 - Software keeps port 0 powered while using broadcast instances.
// RL16 - Offsets 0x00000-0x000fc go to logical/transport group.
// RL17 - Offsets 0x00100-0x003fc go to physical group; 0x00400-0x00ffc reserved.
// RL18 - Offsets 0x01000-0x013bc go to error management; rest to 0x0ffff reserved.
// RL19 - Offsets 0x10000-0x14ffc go to vendor and electrical group.
// RL20 - Fabric, two-wire and utility groups, 256 bytes each; above reserved.
// RL21 - High strap stops the EEPROM boot load after reset.
// RL22 - Low two offset bits ignored; reserved reads zero, writes dropped.
// RL23 - One request at a time; acknowledge carries read data or ends write.
module srd_decode
   import srd_pkg::*;
(
   input  wire logic                               clk_in,
   input  wire logic                               rst_n_in,
   input  wire logic                               load_off_strap_in,
   input  wire logic                               boot_done_in,
   output logic                                    boot_active_out,
   input  wire logic                               mnt_req_in,
   input  wire logic                               mnt_we_in,
   input  wire logic [srd_pkg::ADDR_W-1:0]         mnt_addr_in,
   input  wire logic [srd_pkg::DATA_W-1:0]         mnt_wdata_in,
   input  wire logic                               boot_req_in,
   input  wire logic [srd_pkg::ADDR_W-1:0]         boot_addr_in,
   input  wire logic [srd_pkg::DATA_W-1:0]         boot_wdata_in,
   output logic                                    ack_out,
   output logic      [srd_pkg::DATA_W-1:0]         rdata_out,
   output logic                                    grp_req_out,
   output logic                                    grp_we_out,
   output srd_pkg::srd_grp_e                       grp_sel_out,
   output logic      [srd_pkg::ADDR_W-1:0]         grp_dw_addr_out,
   output logic                                    grp_word_out,
   output logic      [srd_pkg::DATA_W-1:0]         grp_wdata_out,
   output logic                                    grp_boot_out,
   input  wire logic [srd_pkg::DATA_W-1:0]         grp_rdata_in,
   input  wire logic [srd_pkg::NPORT-1:0]          port_pwr_in,
   input  wire logic [srd_pkg::NPORT-1:0][31:0]    port_status_in,
   input  wire logic [srd_pkg::NPORT-1:0][31:0]    port_clr_in,
   output logic      [srd_pkg::NPORT-1:0][31:0]    port_field_out,
   output logic      [srd_pkg::NPORT-1:0][31:0]    port_trigger_out
);
   import srd_pkg::*;

   typedef struct packed {
      srd_boot_e           boot;
      logic [1:0]          wait_cnt;
      logic                strap_ff1;
      logic                strap_ff2;
      logic                pend;
      logic                we;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
      logic                ack;
      logic [DATA_W-1:0]   rdata;
   } srd_dec_s;

   srd_dec_s st;
   srd_dec_s next_st;

   srd_grp_e              grp;
   logic                  fld_hit;
   logic                  fld_bc;
   logic [3:0]            fld_idx;
   logic [NPORT-1:0]      fld_wr;
   logic [NPORT-1:0]      fld_rd;
   logic [NPORT-1:0][31:0] fld_val;
   logic                  take;
   logic [DATA_W-1:0]     fld_rdata;

   // Group decode on the word address; low two bits never take part
   function automatic srd_grp_e grp_of(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] w;
      w = {a[ADDR_W-1:2], 2'b00}; // RL22
      if (w <= LT_HI) begin
         grp_of = SRD_GRP_LT; // RL16
      end else if (w >= PHY_LO && w <= PHY_HI) begin
         grp_of = SRD_GRP_PHY; // RL17
      end else if (w >= EM_LO && w <= EM_HI) begin
         grp_of = SRD_GRP_EM; // RL18
      end else if (w >= VND_LO && w <= VND_HI) begin
         grp_of = SRD_GRP_VND; // RL19
      end else if (w >= SWF_LO && w < SWF_LO + GRP_SPAN) begin
         grp_of = SRD_GRP_SWF; // RL20
      end else if (w >= TWI_LO && w < TWI_LO + GRP_SPAN) begin
         grp_of = SRD_GRP_TWI; // RL20
      end else if (w >= UTIL_LO && w < UTIL_LO + GRP_SPAN) begin
         grp_of = SRD_GRP_UTIL; // RL20
      end else begin
         grp_of = SRD_GRP_NONE; // RL22
      end
   endfunction : grp_of

   // Decode of the pending request, which is held in flip-flops
   always_comb begin
      grp     = grp_of(st.addr);
      fld_idx = st.addr[11:8];
      fld_hit = (st.addr[19:12] == FLD_PAGE) && (st.addr[7:2] == 6'h00)
                && (fld_idx <= FLD_BC);
      fld_bc  = fld_hit && (fld_idx == FLD_BC);
   end

   // Write and read strobes of the per-port field instances
   always_comb begin
      fld_wr = '0;
      fld_rd = '0;
      if (st.pend && fld_hit && st.we) begin
         if (fld_bc) begin
            fld_wr = port_pwr_in; // RL13
         end else begin
            fld_wr[fld_idx[2:0]] = 1'b1;
         end
      end
      if (st.pend && fld_hit && !st.we) begin
         // A broadcast read is served by port 0, clear-on-read included
         fld_rd[fld_bc ? 3'h0 : fld_idx[2:0]] = 1'b1; // RL14
      end
   end

   assign fld_rdata = fld_val[fld_bc ? 3'h0 : fld_idx[2:0]]; // RL14

   // One field instance per port; the lane capability bit is fixed by parity
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      logic [31:0] status;
      always_comb begin
         status = port_status_in[p];
         status[LANE4X_BIT] = (p % 2 == 0); // RL12
      end
      srd_field #(
         .W      (32),
         .RO_M   (M_RO),
         .BOOT_M (M_BOOT),
         .RW_M   (M_RW),
         .W1C_M  (M_W1C),
         .W0C_M  (M_W0C),
         .W1S_M  (M_W1S),
         .RC_M   (M_RC)
      ) u_field (
         .clk_in      (clk_in),
         .rst_n_in    (rst_n_in),
         .boot_in     (st.boot == SRD_BOOT),
         .wr_in       (fld_wr[p]),
         .rd_in       (fld_rd[p]),
         .wdata_in    (st.wdata),
         .hw_set_in   (status),
         .hw_clr_in   (port_clr_in[p]),
         .value_out   (fld_val[p]),
         .trigger_out (port_trigger_out[p])
      );
      assign port_field_out[p] = fld_val[p];
   end

   // A request is taken only when nothing is in flight; boot port owns boot time
   assign take = !st.pend && !st.ack
                 && ((st.boot == SRD_BOOT) ? boot_req_in
                    : (st.boot == SRD_RUN) ? mnt_req_in : 1'b0); // RL23

   // Next-state logic: strap sync, boot sequencing, two-stage access pipe
   always_comb begin
      next_st = st;
      next_st.strap_ff1 = load_off_strap_in;
      next_st.strap_ff2 = st.strap_ff1;
      next_st.ack = 1'b0;
      next_st.pend = take;
      unique case (st.boot)
         SRD_WAIT: begin
            // Wait for the strap to settle through the synchroniser
            next_st.wait_cnt = st.wait_cnt + 2'h1;
            if (st.wait_cnt == STRAP_WAIT) begin
               next_st.boot = st.strap_ff2 ? SRD_RUN : SRD_BOOT; // RL21
            end
         end
         SRD_BOOT: begin
            // Finish only between accesses so a boot write is never cut off
            if (boot_done_in && !st.pend && !take) begin
               next_st.boot = SRD_RUN; // RL3
            end
         end
         SRD_RUN: begin
            next_st.boot = SRD_RUN;
         end
      endcase
      if (take) begin
         if (st.boot == SRD_BOOT) begin
            next_st.we    = 1'b1;
            next_st.addr  = boot_addr_in;
            next_st.wdata = boot_wdata_in;
         end else begin
            next_st.we    = mnt_we_in;
            next_st.addr  = mnt_addr_in;
            next_st.wdata = mnt_wdata_in;
         end
      end
      if (st.pend) begin
         next_st.ack = 1'b1; // RL23
         if (st.we) begin
            next_st.rdata = st.rdata;
         end else if (fld_hit) begin
            next_st.rdata = fld_rdata;
         end else if (grp == SRD_GRP_NONE) begin
            next_st.rdata = '0; // RL22
         end else begin
            next_st.rdata = grp_rdata_in;
         end
      end
   end

   // Single state register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st <= '{boot: SRD_WAIT, default: '0};
      end else begin
         st <= next_st;
      end
   end

   // Group strobe: reserved space and the local field registers never reach a group
   assign grp_req_out     = st.pend && (grp != SRD_GRP_NONE) && !fld_hit; // RL22
   assign grp_we_out      = st.we;
   assign grp_sel_out     = grp;
   // 64-bit double-word address plus word select for protocol-side groups
   assign grp_dw_addr_out = {st.addr[ADDR_W-1:3], 3'b000}; // RL11
   assign grp_word_out    = st.addr[DW_BIT]; // RL11
   assign grp_wdata_out   = st.wdata; // RL10
   assign grp_boot_out    = (st.boot == SRD_BOOT); // RL2
   assign boot_active_out = (st.boot == SRD_BOOT); // RL3
   assign ack_out         = st.ack;
   assign rdata_out       = st.rdata;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   chk_ack_after_take: assert property (take |=> !ack_out ##1 ack_out) // RL23
      else $error("acknowledge not two cycles after request");
   chk_ack_single: assert property (ack_out |=> !ack_out) // RL23
      else $error("acknowledge longer than one cycle");
   chk_rsvd_zero: assert property (st.pend && !st.we && grp == SRD_GRP_NONE // RL22
      |=> ack_out && rdata_out == 32'h00000000)
      else $error("reserved read not zero");
   chk_rsvd_no_strobe: assert property (st.pend && {st.addr[ADDR_W-1:2], 2'b00} > PHY_HI // RL17
      && st.addr < EM_LO |-> !grp_req_out)
      else $error("group strobe on reserved offset");
   chk_lt_decode: assert property (st.pend && st.addr <= LT_HI // RL16
      |-> grp_req_out && grp_sel_out == SRD_GRP_LT)
      else $error("logical group not selected");
   chk_util_span: assert property (st.pend && st.addr >= UTIL_LO + GRP_SPAN // RL20
      |-> !grp_req_out)
      else $error("offset above utility group decoded");
   chk_dw_word: assert property (grp_req_out // RL11
      |-> grp_word_out == st.addr[2] && grp_dw_addr_out[2:0] == 3'b000)
      else $error("double-word mapping wrong");
   chk_bc_write_all: assert property (st.pend && st.we && fld_bc // RL13
      |-> fld_wr == port_pwr_in)
      else $error("broadcast write missed a powered port");
   chk_bc_read_p0: assert property (st.pend && !st.we && fld_bc // RL14
      |=> rdata_out == $past(fld_val[0]))
      else $error("broadcast read not from port 0");
   chk_strap_skip: assert property (st.boot == SRD_WAIT && st.wait_cnt == STRAP_WAIT // RL21
      && st.strap_ff2 |=> !boot_active_out[*3])
      else $error("boot load started with strap high");
   // The capability bit needs one edge after reset to load, hence the past-reset guard
   chk_lane_cap: assert property ($past(rst_n_in) |-> port_field_out[0][LANE4X_BIT] // RL12
      && !port_field_out[1][LANE4X_BIT])
      else $error("lane capability bit wrong");

   cov_bc_write: cover property (st.pend && st.we && fld_bc);
   cov_boot_write: cover property (boot_active_out && take ##2 ack_out);
   cov_rsvd_read: cover property (st.pend && !st.we && grp == SRD_GRP_NONE);
endmodule : srd_decode
`default_nettype wire

/* sim/srd_master_model.sv */
`timescale 1ns/100ps
`default_nettype none
module srd_master_model
   import srd_pkg::*;
(
   input  wire logic                       clk_in,
   input  wire logic                       ack_in,
   input  wire logic [srd_pkg::DATA_W-1:0] rdata_in,
   output logic                            mnt_req_out,
   output logic                            mnt_we_out,
   output logic      [srd_pkg::ADDR_W-1:0] mnt_addr_out,
   output logic      [srd_pkg::DATA_W-1:0] mnt_wdata_out,
   output logic                            boot_req_out,
   output logic      [srd_pkg::ADDR_W-1:0] boot_addr_out,
   output logic      [srd_pkg::DATA_W-1:0] boot_wdata_out
);
   // Idle master at time zero
   initial begin
      {mnt_req_out, mnt_we_out, boot_req_out} = 3'h0;
      {mnt_addr_out, boot_addr_out} = 40'h0;
      {mnt_wdata_out, boot_wdata_out} = 64'h0;
   end

   // One pulse request; lat stays -1 when no acknowledge comes in time
   task automatic access(input logic boot, input logic we, input logic [19:0] addr,
                         input logic [31:0] wdata, output logic [31:0] rdata, output int lat);
      lat = -1;
      rdata = 32'h0;
      @(posedge clk_in);
      if (boot) begin
         boot_req_out <= 1'h1;
         boot_addr_out <= addr;
         boot_wdata_out <= wdata & 32'h00ffffff;
      end else begin
         mnt_req_out <= 1'h1;
         mnt_we_out <= we;
         mnt_addr_out <= addr;
         mnt_wdata_out <= wdata & 32'h00ffffff;
      end
      @(posedge clk_in);
      mnt_req_out <= 1'h0;
      boot_req_out <= 1'h0;
      for (int i = 1; i <= 6 && lat < 0; i++) begin
         @(posedge clk_in);
         if (ack_in === 1'h1) begin
            lat = i;
            rdata = rdata_in;
         end
      end
      // Released lines must not keep showing the old value
      mnt_addr_out <= ~mnt_addr_out;
      mnt_wdata_out <= ~mnt_wdata_out;
      boot_addr_out <= ~boot_addr_out;
      boot_wdata_out <= ~boot_wdata_out;
   endtask : access
endmodule : srd_master_model
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import srd_pkg::*;
   typedef struct packed {
      logic        we;
      logic [19:0] addr;
      logic [31:0] wdata;
      srd_grp_e    sel;
   } srd_row_s;
   localparam srd_row_s ROWS [20] = '{
      '{1'h0, 20'h00000, 32'h0, SRD_GRP_LT}, '{1'h0, 20'h000fc, 32'h0, SRD_GRP_LT},
      '{1'h1, 20'h00008, 32'hc0ffee, SRD_GRP_LT}, '{1'h0, 20'h00100, 32'h0, SRD_GRP_PHY},
      '{1'h0, 20'h003fc, 32'h0, SRD_GRP_PHY}, '{1'h0, 20'h00400, 32'h0, SRD_GRP_NONE},
      '{1'h1, 20'h00ffc, 32'h123456, SRD_GRP_NONE}, '{1'h0, 20'h01000, 32'h0, SRD_GRP_EM},
      '{1'h0, 20'h013bc, 32'h0, SRD_GRP_EM}, '{1'h0, 20'h013c0, 32'h0, SRD_GRP_NONE},
      '{1'h0, 20'h0fffc, 32'h0, SRD_GRP_NONE}, '{1'h0, 20'h10004, 32'h0, SRD_GRP_VND},
      '{1'h1, 20'h14ffc, 32'habcdef, SRD_GRP_VND}, '{1'h0, 20'h15000, 32'h0, SRD_GRP_NONE},
      '{1'h0, 20'h1a9fc, 32'h0, SRD_GRP_NONE}, '{1'h0, 20'h1aaff, 32'h0, SRD_GRP_SWF},
      '{1'h1, 20'h1ab00, 32'h777777, SRD_GRP_TWI}, '{1'h0, 20'h1acfc, 32'h0, SRD_GRP_UTIL},
      '{1'h0, 20'h1ad00, 32'h0, SRD_GRP_NONE}, '{1'h0, 20'hffffc, 32'h0, SRD_GRP_NONE}};
   logic              clk, rst_n, strap, boot_done, boot_active, ack;
   logic              mnt_req, mnt_we, boot_req, grp_req, grp_we, grp_word, grp_boot;
   logic [19:0]       mnt_addr, boot_addr, grp_dw;
   logic [31:0]       mnt_wdata, boot_wdata, rdata, grp_wdata, grp_rdata;
   srd_grp_e          grp_sel, cap_sel;
   logic [7:0]        pwr;
   logic [7:0][31:0]  status, field, trig, trig_seen;
   logic [31:0]       cap_wdata;
   logic [19:0]       cap_dw;
   logic              cap_word, cap_we, cap_boot;
   int                n_errors = 0, tests_run = 0, cyc = 0, n_strobe = 0;

   // Group answers with a tag of the address; pattern churns while not strobed
   function automatic logic [31:0] resp(input logic [19:0] dw, input logic w);
      return {11'h2a5, w, dw};
   endfunction : resp
   assign grp_rdata = grp_req ? resp(grp_dw, grp_word) : 32'(cyc) * 32'h9e37;

   srd_decode srd_decode_i (.clk_in(clk), .rst_n_in(rst_n), .load_off_strap_in(strap),
      .boot_done_in(boot_done), .boot_active_out(boot_active), .mnt_req_in(mnt_req),
      .mnt_we_in(mnt_we), .mnt_addr_in(mnt_addr), .mnt_wdata_in(mnt_wdata),
      .boot_req_in(boot_req), .boot_addr_in(boot_addr), .boot_wdata_in(boot_wdata),
      .ack_out(ack), .rdata_out(rdata), .grp_req_out(grp_req), .grp_we_out(grp_we),
      .grp_sel_out(grp_sel), .grp_dw_addr_out(grp_dw), .grp_word_out(grp_word),
      .grp_wdata_out(grp_wdata), .grp_boot_out(grp_boot), .grp_rdata_in(grp_rdata),
      .port_pwr_in(pwr), .port_status_in(status), .port_clr_in(256'h0),
      .port_field_out(field), .port_trigger_out(trig));
   srd_master_model srd_master_model_i (.clk_in(clk), .ack_in(ack), .rdata_in(rdata),
      .mnt_req_out(mnt_req), .mnt_we_out(mnt_we), .mnt_addr_out(mnt_addr),
      .mnt_wdata_out(mnt_wdata), .boot_req_out(boot_req), .boot_addr_out(boot_addr),
      .boot_wdata_out(boot_wdata));

   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   // Strobe and trigger monitor, plus the hang guard
   always @(posedge clk) begin
      cyc++;
      if (grp_req === 1'h1) begin
         n_strobe++;
         {cap_sel, cap_dw, cap_word, cap_we, cap_boot} = {grp_sel, grp_dw, grp_word, grp_we, grp_boot};
         cap_wdata = grp_wdata;
      end
      for (int p = 0; p < 8; p++) trig_seen[p] = trig_seen[p] | trig[p];
      if (cyc == 20000) begin
         n_errors++;
         test_done();
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic acc(input logic boot, input logic we, input logic [19:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rd);
      int lat;
      srd_master_model_i.access(boot, we, addr, wdata, rd, lat);
      check("ack latency", 32'(lat), 32'h2);
   endtask : acc

   task automatic refused(input logic boot, input logic [19:0] addr);
      int lat;
      logic [31:0] rd;
      srd_master_model_i.access(boot, boot, addr, 32'h0, rd, lat);
      check("refused ack", 32'(lat), 32'hffffffff);
   endtask : refused

   function automatic logic [19:0] fa(input int p);
      return {8'h10, 4'(p), 8'h00};
   endfunction : fa

   task automatic test_done();
      if (n_errors == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done

   initial begin
      logic [31:0] rd;
      int n0;
      {rst_n, strap, boot_done, pwr, status, trig_seen} <= '0;
      pwr <= 8'hff;
      repeat (3) @(posedge clk);
      check("outputs in reset", {ack, boot_active, grp_req, |field}, 32'h0);
      rst_n <= 1'h1;
      for (int i = 0; i < 10 && boot_active !== 1'h1; i++) @(posedge clk);
      check("boot active", {31'h0, boot_active}, 32'h1);
      refused(1'h0, 20'h00000);
      acc(1'h1, 1'h1, fa(0), 32'hf8, rd);
      n0 = n_strobe;
      acc(1'h1, 1'h1, 20'h00068, 32'h1234, rd);
      check("boot strobe", {30'(n_strobe - n0), cap_boot, cap_we}, {30'h1, 2'h3});
      @(posedge clk);
      boot_done <= 1'h1;
      @(posedge clk);
      boot_done <= 1'h0;
      for (int i = 0; i < 10 && boot_active !== 1'h0; i++) @(posedge clk);
      acc(1'h0, 1'h0, fa(0), 32'h0, rd);
      check("boot-time field", rd, 32'hf9);
      acc(1'h0, 1'h1, fa(0), 32'h0, rd);
      acc(1'h0, 1'h0, fa(0), 32'h0, rd);
      check("run-time field", rd, 32'h09);
      // Decode table
      foreach (ROWS[i]) begin
         n0 = n_strobe;
         acc(1'h0, ROWS[i].we, ROWS[i].addr, ROWS[i].wdata, rd);
         check("strobe count", n_strobe - n0, {31'h0, ROWS[i].sel != SRD_GRP_NONE});
         if (ROWS[i].sel != SRD_GRP_NONE) begin
            check("group", 32'(cap_sel), 32'(ROWS[i].sel));
            check("dw addr", {12'h0, cap_dw}, {12'h0, ROWS[i].addr[19:3], 3'h0});
            check("word", {31'h0, cap_word}, {31'h0, ROWS[i].addr[2]});
            check("we boot", {cap_we, cap_boot}, {ROWS[i].we, 1'h0});
            if (ROWS[i].we) check("wdata", cap_wdata, ROWS[i].wdata);
         end
         if (!ROWS[i].we) begin
            if (ROWS[i].sel == SRD_GRP_NONE) check("reserved rd", rd, 32'h0);
            else check("rdata", rd, resp({ROWS[i].addr[19:3], 3'h0}, ROWS[i].addr[2]));
         end
      end
      // Access kinds on port 2
      status[2] <= 32'h00f0ff06;
      @(posedge clk);
      status[2] <= 32'h6;
      acc(1'h0, 1'h0, fa(2), 32'h0, rd);
      check("hw set", rd, 32'h00f0ff07);
      trig_seen <= '0;
      acc(1'h0, 1'h1, fa(2), 32'h00535500, rd);
      check("trigger", trig_seen[2] | trig[2], 32'h00030000);
      acc(1'h0, 1'h0, fa(2), 32'h0, rd);
      check("kinds", rd, 32'h00535a07);
      acc(1'h0, 1'h0, fa(2), 32'h0, rd);
      check("clear on read", rd, 32'h00035a07);
      // Broadcast with port 6 off and port 0 on
      pwr <= 8'hbf;
      acc(1'h0, 1'h1, fa(8), 32'ha0, rd);
      for (int p = 0; p < 8; p++) begin
         acc(1'h0, 1'h0, fa(p), 32'h0, rd);
         check("bc low byte", {24'h0, rd[7:0]},
               {24'h0, (p == 6) ? 4'h0 : 4'ha, p == 0, (p == 2) ? 2'h3 : 2'h0, ~p[0]});
      end
      acc(1'h0, 1'h0, fa(8), 32'h0, rd);
      check("bc read", rd, 32'ha9);
      check("field port 0", field[0], 32'ha9);
      pwr <= 8'hff;
      refused(1'h1, fa(0));
      // Second reset with the strap high skips the boot phase
      @(posedge clk);
      rst_n <= 1'h0;
      strap <= 1'h1;
      repeat (3) @(posedge clk);
      rst_n <= 1'h1;
      repeat (10) @(posedge clk);
      check("no boot", {31'h0, boot_active}, 32'h0);
      acc(1'h0, 1'h0, fa(1), 32'h0, rd);
      check("odd port", rd, 32'h0);
      acc(1'h0, 1'h0, fa(0), 32'h0, rd);
      check("even port", rd, 32'h1);
      test_done();
   end
endmodule : tb_top
`default_nettype wire
